// *** include/ubl_map.vh ***
// Purpose: constants of the serial receive/control block
// Assumes: one 250 MHz clock; bit time in clock cycles is given by software
// Notes:   field codes are those of the width/parity and pin-usage fields
`ifndef UBL_MAP_VH
`define UBL_MAP_VH

// ****************************************
// width / parity field codes
// ****************************************
`define UBL_WP_8N        2'h0
`define UBL_WP_8E        2'h1
`define UBL_WP_8O        2'h2
`define UBL_WP_9N        2'h3

// ****************************************
// pin usage field codes
// ****************************************
`define UBL_PU_NONE      2'h0
`define UBL_PU_RTS       2'h1
`define UBL_PU_RTS_CTS   2'h2
`define UBL_PU_BCLK      2'h3

// ****************************************
// sizes and timing
// ****************************************
`define UBL_FIFO_DEPTH   4
`define UBL_CHAR_W       9
`define UBL_DIV_W        16
`define UBL_DIV_RESET    16'h0043
`define UBL_BREAK_BITS   13
`define UBL_IRQ_LVL_3OF4 3'h3
`define UBL_IRQ_LVL_FULL 3'h4

`endif

// *** rtl/ubl_pin_route.v ***
// Purpose: steering of receive line, flow-control and capture inputs
// Assumes: all inputs synchronous to clock
// Notes:   purely combinational; the top registers what leaves the chip
`timescale 1ns/100ps
`include "ubl_map.vh"

module ubl_pin_route (
   input  wire       module_enable_bit,
   input  wire       loopback_select,
   input  wire [1:0] pin_usage_field,
   input  wire       auto_rate_route_bit,
   input  wire       serial_in_pin,
   input  wire       tx_line,
   input  wire       rts_n,
   input  wire       clear_to_send_pin_n,
   input  wire       capture_input_pin,
   output wire       rx_line,
   output wire       cts_n,
   output wire       cts_used,
   output wire       rts_used,
   output wire       bclk_used,
   output wire       capture_channel_in
);

   wire route_on;

   // receive pin cut off while looping back
   assign rx_line  = loopback_select ? tx_line : serial_in_pin;

   // in loopback only code 10 feeds cts from our own rts
   assign cts_used = (pin_usage_field == `UBL_PU_RTS_CTS);
   assign cts_n    = (loopback_select && cts_used) ? rts_n
                                                   : clear_to_send_pin_n;
   assign rts_used = (pin_usage_field == `UBL_PU_RTS) ||
                     (pin_usage_field == `UBL_PU_RTS_CTS);
   assign bclk_used = (pin_usage_field == `UBL_PU_BCLK);

   assign route_on = auto_rate_route_bit && module_enable_bit &&
                     !loopback_select;
   assign capture_channel_in = route_on ? serial_in_pin
                                        : capture_input_pin;

endmodule

// *** rtl/ubl_rx_fifo.v ***
// Purpose: receive character store with framing flag per entry
// Assumes: push is ignored when full; pop is ignored when empty
// Notes:   flip-flop storage, index addressed
`timescale 1ns/100ps
`include "ubl_map.vh"

module ubl_rx_fifo #(
   parameter W     = `UBL_CHAR_W,
   parameter DEPTH = `UBL_FIFO_DEPTH,
   parameter AW    = 2
) (
   input  wire          clock,
   input  wire          rst,
   input  wire          push,
   input  wire [W-1:0]  push_data,
   input  wire          push_frame_err,
   input  wire          pop,
   output wire [W-1:0]  head_data,
   output wire          head_frame_err,
   output reg  [AW:0]   count_r,
   output wire          empty,
   output wire          full
);

   reg [W:0]    mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_r;
   reg [AW-1:0] rd_r;
   wire         do_push;
   wire         do_pop;
   integer      i;

   assign empty   = (count_r == {(AW+1){1'b0}});
   assign full    = (count_r == DEPTH[AW:0]);
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;
   assign head_data = mem_r[rd_r][W-1:0];
   assign head_frame_err = mem_r[rd_r][W];

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_r    <= {AW{1'b0}};
         rd_r    <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_r[i] <= {(W+1){1'b0}};
         end
      end else begin
         if (do_push) begin
            mem_r[wr_r] <= {push_frame_err, push_data};
            wr_r        <= wr_r + 1'b1;
         end
         if (do_pop) begin
            rd_r <= rd_r + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_r <= count_r + 1'b1;
         end else if (do_pop && !do_push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

// *** rtl/ubl_top.v ***
// Purpose: serial transceiver core with break, loopback, routing and power
// Assumes: inputs synchronous to clock; bit time = rate_divisor+1 cycles
// Notes:   no parity error check; a full store drops new characters
`timescale 1ns/100ps
`include "ubl_map.vh"

module ubl_top #(
   parameter DW = `UBL_DIV_W
) (
   input  wire          clock,
   input  wire          rst,
   input  wire          module_enable_bit,
   input  wire          transmit_enable_bit,
   input  wire          loopback_select,
   input  wire [1:0]    pin_usage_field,
   input  wire          auto_rate_route_bit,
   input  wire          wake_bit,
   input  wire          rx_irq_enable,
   input  wire [1:0]    rx_irq_select,
   input  wire          halt_in_idle_bit,
   input  wire [1:0]    width_parity_select,
   input  wire          stop_count_select,
   input  wire [DW-1:0] rate_divisor,
   input  wire          sleep_mode,
   input  wire          idle_mode,
   input  wire [8:0]    tx_data,
   input  wire          tx_valid,
   output wire          tx_ready,
   input  wire          rx_pop,
   output wire [8:0]    rx_data,
   output wire          rx_char_frame_err,
   output wire          rx_data_available,
   output reg           framing_error_flag,
   output reg           receiver_idle_flag,
   output reg           rx_irq,
   input  wire          serial_in_pin,
   output reg           serial_out_pin,
   input  wire          clear_to_send_pin_n,
   output reg           request_to_send_pin_n,
   output reg           request_to_send_oe_n,
   output reg           baud_clk_pin,
   output reg           baud_clk_oe_n,
   input  wire          capture_input_pin,
   output wire          capture_channel_in
);

   // ****************************************
   // receiver states
   // ****************************************
   localparam RX_IDLE  = 3'h0;
   localparam RX_START = 3'h1;
   localparam RX_BITS  = 3'h2;
   localparam RX_STOP  = 3'h3;
   localparam RX_WAITH = 3'h4;

   // ****************************************
   // declarations
   // ****************************************
   reg  [2:0]    rx_st_r;
   reg  [DW-1:0] rx_cnt_r;
   reg  [3:0]    rx_bit_r;
   reg  [9:0]    rx_sh_r;
   reg           rx_prev_r;
   reg           pin_prev_r;
   reg           rx_push_r;
   reg           rx_frame_err_r;
   reg  [8:0]    rx_word_r;
   reg           tx_en_r;
   reg           txe_prev_r;
   reg           tx_busy_r;
   reg  [12:0]   tx_sh_r;
   reg  [3:0]    tx_left_r;
   reg  [DW-1:0] tx_cnt_r;
   wire          halt;
   wire          rx_line;
   wire          cts_n;
   wire          cts_used;
   wire          rts_used;
   wire          bclk_used;
   wire [3:0]    data_bits;
   wire [3:0]    body_bits;
   wire          par_on;
   wire          par_odd;
   wire [DW-1:0] half_bit;
   wire          fifo_empty;
   wire          fifo_full;
   wire [2:0]    fifo_cnt;
   wire          tx_par;
   wire          start_tx;
   wire          wake_edge;
   reg           irq_lvl_ok;

   // ****************************************
   // configuration decode
   // ****************************************
   // 9-bit mode has no parity; stop count adds one or two bits
   assign data_bits = (width_parity_select == `UBL_WP_9N) ? 4'h9 : 4'h8;
   assign par_on  = (width_parity_select == `UBL_WP_8E) ||
                    (width_parity_select == `UBL_WP_8O);
   assign par_odd = (width_parity_select == `UBL_WP_8O);
   assign body_bits = data_bits + {3'h0, par_on};
   assign half_bit  = {1'b0, rate_divisor[DW-1:1]};

   // stopped when disabled, asleep, or idle with halt bit set
   assign halt = !module_enable_bit || sleep_mode ||
                 (idle_mode && halt_in_idle_bit);

   // ****************************************
   // pin steering
   // ****************************************
   ubl_pin_route u_route (
      .module_enable_bit   (module_enable_bit),
      .loopback_select     (loopback_select),
      .pin_usage_field     (pin_usage_field),
      .auto_rate_route_bit (auto_rate_route_bit),
      .serial_in_pin       (serial_in_pin),
      .tx_line             (serial_out_pin),
      .rts_n               (request_to_send_pin_n),
      .clear_to_send_pin_n (clear_to_send_pin_n),
      .capture_input_pin   (capture_input_pin),
      .rx_line             (rx_line),
      .cts_n               (cts_n),
      .cts_used            (cts_used),
      .rts_used            (rts_used),
      .bclk_used           (bclk_used),
      .capture_channel_in  (capture_channel_in)
   );

   // ****************************************
   // receive store
   // ****************************************
   ubl_rx_fifo #(
      .W     (`UBL_CHAR_W),
      .DEPTH (`UBL_FIFO_DEPTH),
      .AW    (2)
   ) u_fifo (
      .clock          (clock),
      .rst            (rst),
      .push           (rx_push_r),
      .push_data      (rx_word_r),
      .push_frame_err (rx_frame_err_r),
      .pop            (rx_pop),
      .head_data      (rx_data),
      .head_frame_err (rx_char_frame_err),
      .count_r        (fifo_cnt),
      .empty          (fifo_empty),
      .full           (fifo_full)
   );

   assign rx_data_available = !fifo_empty;

   // ****************************************
   // receiver
   // ****************************************
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_st_r            <= RX_IDLE;
         rx_cnt_r           <= {DW{1'b0}};
         rx_bit_r           <= 4'h0;
         rx_sh_r            <= 10'h000;
         rx_prev_r          <= 1'b1;
         rx_push_r          <= 1'b0;
         rx_frame_err_r     <= 1'b0;
         rx_word_r          <= 9'h000;
         framing_error_flag <= 1'b0;
         receiver_idle_flag <= 1'b1;
      end else begin
         rx_prev_r <= rx_line;
         rx_push_r <= 1'b0;
         if (!fifo_empty) begin
            framing_error_flag <= rx_char_frame_err;
         end else begin
            framing_error_flag <= 1'b0;
         end
         if (halt) begin
            rx_st_r            <= RX_IDLE;
            receiver_idle_flag <= 1'b1;
         end else begin
            case (rx_st_r)
               RX_IDLE: begin
                  if (rx_prev_r && !rx_line) begin
                     rx_st_r            <= RX_START;
                     rx_cnt_r           <= half_bit;
                     receiver_idle_flag <= 1'b0;
                  end
               end
               RX_START: begin
                  if (rx_cnt_r != {DW{1'b0}}) begin
                     rx_cnt_r <= rx_cnt_r - 1'b1;
                  end else if (rx_line) begin
                     // glitch, not a start bit
                     rx_st_r            <= RX_IDLE;
                     receiver_idle_flag <= 1'b1;
                  end else begin
                     rx_st_r  <= RX_BITS;
                     rx_cnt_r <= rate_divisor;
                     rx_bit_r <= 4'h0;
                  end
               end
               RX_BITS: begin
                  if (rx_cnt_r != {DW{1'b0}}) begin
                     rx_cnt_r <= rx_cnt_r - 1'b1;
                  end else begin
                     rx_sh_r  <= {rx_line, rx_sh_r[9:1]};
                     rx_cnt_r <= rate_divisor;
                     rx_bit_r <= rx_bit_r + 1'b1;
                     if (rx_bit_r + 1'b1 == body_bits) begin
                        rx_st_r <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  // only the first stop bit is checked
                  if (rx_cnt_r != {DW{1'b0}}) begin
                     rx_cnt_r <= rx_cnt_r - 1'b1;
                  end else begin
                     rx_push_r <= 1'b1;
                     rx_frame_err_r <= !rx_line;
                     if (par_on) begin
                        rx_word_r <= {1'b0, rx_sh_r[8:1]};
                     end else if (data_bits == 4'h9) begin
                        rx_word_r <= rx_sh_r[9:1];
                     end else begin
                        rx_word_r <= {1'b0, rx_sh_r[9:2]};
                     end
                     if (rx_line) begin
                        rx_st_r            <= RX_IDLE;
                        receiver_idle_flag <= 1'b1;
                     end else begin
                        rx_st_r <= RX_WAITH;
                     end
                  end
               end
               RX_WAITH: begin
                  // low line is not a new start bit
                  if (rx_line) begin
                     rx_st_r            <= RX_IDLE;
                     receiver_idle_flag <= 1'b1;
                  end
               end
               default: begin
                  rx_st_r <= RX_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************
   // receive interrupt and wake
   // ****************************************
   assign wake_edge = sleep_mode && wake_bit && rx_irq_enable &&
                      module_enable_bit && pin_prev_r &&
                      !serial_in_pin;

   always @* begin
      case (rx_irq_select)
         2'h2:    irq_lvl_ok = (fifo_cnt >= `UBL_IRQ_LVL_3OF4);
         2'h3:    irq_lvl_ok = (fifo_cnt == `UBL_IRQ_LVL_FULL);
         default: irq_lvl_ok = 1'b1;
      endcase
   end

   // irq judged a cycle after the push, once the count has moved
   reg push_d_r;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_prev_r <= 1'b1;
         push_d_r   <= 1'b0;
         rx_irq     <= 1'b0;
      end else begin
         pin_prev_r <= serial_in_pin;
         push_d_r   <= rx_push_r && !fifo_full;
         rx_irq     <= (rx_irq_enable && push_d_r && irq_lvl_ok) ||
                       wake_edge;
      end
   end

   // ****************************************
   // transmitter
   // ****************************************
   assign tx_par = ^tx_data[7:0] ^ par_odd;
   assign tx_ready = tx_en_r && !tx_busy_r && !halt &&
                     !(cts_used && cts_n);
   assign start_tx = tx_ready && tx_valid;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_en_r    <= 1'b0;
         txe_prev_r <= 1'b0;
         tx_busy_r  <= 1'b0;
         tx_sh_r    <= 13'h1FFF;
         tx_left_r  <= 4'h0;
         tx_cnt_r   <= {DW{1'b0}};
         serial_out_pin <= 1'b1;
      end else begin
         txe_prev_r <= transmit_enable_bit;
         // enable only taken on a rise seen while module is on
         if (!transmit_enable_bit || !module_enable_bit) begin
            tx_en_r <= 1'b0;
         end else if (!txe_prev_r) begin
            tx_en_r <= 1'b1;
         end
         if (halt) begin
            tx_busy_r      <= 1'b0;
            serial_out_pin <= 1'b1;
         end else if (start_tx) begin
            tx_busy_r <= 1'b1;
            tx_cnt_r  <= rate_divisor;
            // every bit after the start bit, stops included
            tx_left_r <= body_bits + {3'h0, stop_count_select} +
                         4'h1;
            serial_out_pin <= 1'b0;
            if (par_on) begin
               tx_sh_r <= {4'hF, tx_par, tx_data[7:0]};
            end else if (data_bits == 4'h9) begin
               tx_sh_r <= {3'h7, 1'b1, tx_data};
            end else begin
               tx_sh_r <= {4'hF, 1'b1, tx_data[7:0]};
            end
         end else if (tx_busy_r) begin
            if (tx_cnt_r != {DW{1'b0}}) begin
               tx_cnt_r <= tx_cnt_r - 1'b1;
               // free a cycle early so a queued start bit keeps full stops
               if (tx_cnt_r == {{(DW-1){1'b0}}, 1'b1} &&
                   tx_left_r == 4'h0) begin
                  tx_busy_r <= 1'b0;
               end
            end else begin
               tx_cnt_r       <= rate_divisor;
               serial_out_pin <= tx_sh_r[0];
               tx_sh_r        <= {1'b1, tx_sh_r[12:1]};
               if (tx_left_r != 4'h0) begin
                  tx_left_r <= tx_left_r - 1'b1;
               end
            end
         end
      end
   end

   // ****************************************
   // side pins
   // ****************************************
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         request_to_send_pin_n <= 1'b1;
         request_to_send_oe_n  <= 1'b1;
         baud_clk_pin          <= 1'b0;
         baud_clk_oe_n         <= 1'b1;
      end else begin
         // rts asks for data while the store has room and the block is not halted
         request_to_send_pin_n <= fifo_full || halt;
         request_to_send_oe_n  <= !(rts_used && module_enable_bit);
         baud_clk_pin  <= (tx_cnt_r > half_bit);
         baud_clk_oe_n <= !(bclk_used && module_enable_bit);
      end
   end

endmodule

// *** tb/ubl_checker.sv ***
// Purpose: port-level checks of the serial control block
// Assumes: one clock, async active-high reset
// Notes:   two-cycle antecedents allow one register stage
`timescale 1ns/100ps

module ubl_checker (
   input logic       clock,
   input logic       rst,
   input logic       sleep_mode,
   input logic       idle_mode,
   input logic       halt_in_idle_bit,
   input logic       serial_out_pin,
   input logic       rx_data_available,
   input logic       rx_pop,
   input logic       rx_char_frame_err,
   input logic       framing_error_flag,
   input logic       auto_rate_route_bit,
   input logic       module_enable_bit,
   input logic       loopback_select,
   input logic       serial_in_pin,
   input logic       capture_input_pin,
   input logic       capture_channel_in,
   input logic       wake_bit,
   input logic       rx_irq_enable,
   input logic       rx_irq,
   input logic [1:0] pin_usage_field,
   input logic       request_to_send_oe_n,
   input logic       baud_clk_oe_n
);
   // ******************************
   // assertions
   // ******************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sleep_tx_a: assert property (sleep_mode [*2] |=> serial_out_pin)
      else $error("tx pin not high in sleep");
   halt_tx_a: assert property ((idle_mode && halt_in_idle_bit) [*2]
      |=> serial_out_pin) else $error("tx pin not high when halted");
   wake_irq_a: assert property (sleep_mode && wake_bit && rx_irq_enable
      && module_enable_bit && $fell(serial_in_pin) |-> ##[1:2] rx_irq)
      else $error("no wake interrupt");
   wake_off_a: assert property ((sleep_mode && !module_enable_bit) [*2]
      |=> !rx_irq) else $error("wake interrupt while disabled");
   avail_hold_a: assert property (rx_data_available && !rx_pop
      |=> rx_data_available) else $error("data available dropped");
   frame_head_a: assert property ($past(rx_data_available)
      |-> framing_error_flag == $past(rx_char_frame_err))
      else $error("framing flag not from head entry");
   route_on_a: assert property (auto_rate_route_bit && module_enable_bit
      && !loopback_select |-> capture_channel_in == serial_in_pin)
      else $error("capture not fed from receive pin");
   route_off_a: assert property (!(auto_rate_route_bit && module_enable_bit
      && !loopback_select) |-> capture_channel_in == capture_input_pin)
      else $error("capture pin not passed through");
   lb_none_a: assert property ((loopback_select && pin_usage_field == 2'h0)
      [*2] |-> request_to_send_oe_n && baud_clk_oe_n)
      else $error("side pin driven with code 00");
   lb_rts_a: assert property ((loopback_select && pin_usage_field[1]
      != pin_usage_field[0]) [*2] |-> !request_to_send_oe_n && baud_clk_oe_n)
      else $error("rts pin not driven");
   lb_bclk_a: assert property ((loopback_select && pin_usage_field == 2'h3)
      [*2] |-> !baud_clk_oe_n && request_to_send_oe_n)
      else $error("baud clock pin not driven");
endmodule

// *** tb/ubl_peer_model.sv ***
// Purpose: remote serial peer driving the receive pin
// Assumes: bit time of BT clock cycles, line idles high
// Notes:   clear-to-send held off unless the bench lowers it
`timescale 1ns/100ps

module ubl_peer_model #(
   parameter BT = 4
) (
   input  logic clock,
   output logic line,
   output logic cts_n
);
   // ******************************
   // line driver
   // ******************************
   initial begin
      line = 1'b1;
      cts_n = 1'b1;
   end

   task lv(input logic b);
      line = b;
   endtask

   task flow(input logic b);
      cts_n = b;
   endtask

   task send(input logic [8:0] d, input int nb);
      int i;
      line = 1'b0;
      repeat (BT) @(negedge clock);
      for (i = 0; i < nb; i++) begin
         line = d[i];
         repeat (BT) @(negedge clock);
      end
      line = 1'b1;
      repeat (BT) @(negedge clock);
   endtask
endmodule

// *** tb/ubl_top_bench.sv ***
// Purpose: directed tests of break, loopback, routing, sleep and idle
// Assumes: bit time 4 cycles (divisor 3); the loopback test runs at 5 cycles (divisor 4)
// Notes:   inputs change at the falling edge only
`timescale 1ns/100ps

module ubl_top_bench;
   logic clock = 1'b0;
   logic rst, module_enable_bit, transmit_enable_bit, loopback_select;
   logic auto_rate_route_bit, wake_bit, rx_irq_enable, halt_in_idle_bit;
   logic stop_count_select, sleep_mode, idle_mode, tx_valid, rx_pop;
   logic capture_input_pin;
   logic [1:0]  pin_usage_field, rx_irq_select, width_parity_select;
   logic [15:0] rate_divisor;
   logic [8:0]  tx_data;
   wire  [8:0]  rx_data;
   wire tx_ready, rx_char_frame_err, rx_data_available, framing_error_flag;
   wire receiver_idle_flag, rx_irq, serial_in_pin, serial_out_pin;
   wire clear_to_send_pin_n, request_to_send_pin_n, request_to_send_oe_n;
   wire baud_clk_pin, baud_clk_oe_n, capture_channel_in;
   int  n_errors = 0, total_checks = 0, u, c;

   ubl_top dut_u (.*);
   ubl_peer_model peer_u (.clock(clock), .line(serial_in_pin),
      .cts_n(clear_to_send_pin_n));

   always #2 clock = ~clock;

   // ******************************
   // tasks
   // ******************************
   task chk(input logic [8:0] got, input logic [8:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task take(input logic [8:0] d);
      int i;
      for (i = 0; i < 300 && rx_data_available !== 1'b1; i++) cyc(1);
      chk(9'(rx_data_available), 9'h001);
      chk(rx_data, d);
      rx_pop = 1'b1;
      cyc(1);
      rx_pop = 1'b0;
      cyc(1);
   endtask
   task send(input logic [8:0] d);
      int i;
      for (i = 0; i < 100 && tx_ready !== 1'b1; i++) cyc(1);
      tx_data = d;
      tx_valid = 1'b1;
      cyc(1);
      tx_valid = 1'b0;
   endtask
   task irqs(output int n);
      n = 0;
      repeat (4) begin
         cyc(1);
         if (rx_irq === 1'b1) n++;
      end
   endtask
   // transmit enable must rise again after module enable
   task reen;
      module_enable_bit = 1'b1;
      transmit_enable_bit = 1'b0;
      cyc(1);
      transmit_enable_bit = 1'b1;
      cyc(1);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ******************************
   // tests
   // ******************************
   initial begin
      {rst, module_enable_bit, transmit_enable_bit, loopback_select} = 4'h8;
      {auto_rate_route_bit, wake_bit, rx_irq_enable} = 3'h0;
      {halt_in_idle_bit, stop_count_select, sleep_mode, idle_mode} = 4'h0;
      {tx_valid, rx_pop, capture_input_pin} = 3'h0;
      {pin_usage_field, rx_irq_select, width_parity_select} = 6'h00;
      rate_divisor = 16'h0003;
      tx_data = 9'h000;
      cyc(16);
      rst = 1'b0;
      reen;
      peer_u.send(9'h0A5, 8);
      take(9'h0A5);
      width_parity_select = 2'h3;
      peer_u.send(9'h1C3, 9);
      take(9'h1C3);
      width_parity_select = 2'h0;
      $display("widths done");
      peer_u.lv(1'b0);
      cyc(80);
      chk(9'(rx_data_available), 9'h001);
      chk(rx_data, 9'h000);
      chk(9'(rx_char_frame_err), 9'h001);
      chk(9'(framing_error_flag), 9'h001);
      chk(9'(receiver_idle_flag), 9'h000);
      take(9'h000);
      cyc(60);
      chk(9'(rx_data_available), 9'h000);
      chk(9'(receiver_idle_flag), 9'h000);
      peer_u.lv(1'b1);
      cyc(10);
      chk(9'(receiver_idle_flag), 9'h001);
      peer_u.send(9'h05A, 8);
      take(9'h05A);
      $display("break done");
      loopback_select = 1'b1;
      rate_divisor = 16'h0004;
      cyc(2);
      peer_u.lv(1'b0);
      for (u = 0; u < 4; u++) begin
         pin_usage_field = u[1:0];
         width_parity_select = u[1:0] ^ 2'h1;
         stop_count_select = u[0];
         cyc(3);
         chk(9'(request_to_send_oe_n), 9'(u == 0 || u == 3));
         chk(9'(baud_clk_oe_n), 9'(u != 3));
         send(9'h030 + 9'(u));
         take(9'h030 + 9'(u));
      end
      {pin_usage_field, width_parity_select, stop_count_select} = 5'h00;
      rate_divisor = 16'h0003;
      peer_u.lv(1'b1);
      cyc(2);
      loopback_select = 1'b0;
      pin_usage_field = 2'h2;
      cyc(2);
      chk(9'(tx_ready), 9'h000);
      chk(9'(request_to_send_pin_n), 9'h000);
      peer_u.flow(1'b0);
      cyc(1);
      chk(9'(tx_ready), 9'h001);
      peer_u.flow(1'b1);
      pin_usage_field = 2'h0;
      $display("loopback done");
      auto_rate_route_bit = 1'b1;
      capture_input_pin = 1'b1;
      peer_u.lv(1'b0);
      cyc(1);
      chk(9'(capture_channel_in), 9'h000);
      capture_input_pin = 1'b0;
      peer_u.lv(1'b1);
      cyc(1);
      chk(9'(capture_channel_in), 9'h001);
      loopback_select = 1'b1;
      cyc(1);
      chk(9'(capture_channel_in), 9'h000);
      {loopback_select, module_enable_bit, capture_input_pin} = 3'h1;
      peer_u.lv(1'b0);
      cyc(1);
      chk(9'(capture_channel_in), 9'h001);
      peer_u.lv(1'b1);
      auto_rate_route_bit = 1'b0;
      capture_input_pin = 1'b0;
      reen;
      $display("routing done");
      send(9'h000);
      cyc(8);
      sleep_mode = 1'b1;
      cyc(3);
      chk(9'(serial_out_pin), 9'h001);
      cyc(20);
      sleep_mode = 1'b0;
      cyc(60);
      fork
         peer_u.send(9'h0FF, 8);
         begin
            cyc(10);
            sleep_mode = 1'b1;
            cyc(10);
            sleep_mode = 1'b0;
         end
      join
      cyc(20);
      chk(9'(rx_data_available), 9'h000);
      {sleep_mode, wake_bit, rx_irq_enable, rx_irq_select} = 5'h1F;
      cyc(2);
      peer_u.lv(1'b0);
      irqs(c);
      chk(9'(c), 9'h001);
      peer_u.lv(1'b1);
      module_enable_bit = 1'b0;
      cyc(2);
      peer_u.lv(1'b0);
      irqs(c);
      chk(9'(c), 9'h000);
      peer_u.lv(1'b1);
      cyc(2);
      {sleep_mode, wake_bit} = 2'h0;
      reen;
      $display("sleep done");
      halt_in_idle_bit = 1'b1;
      send(9'h000);
      cyc(8);
      idle_mode = 1'b1;
      cyc(3);
      chk(9'(serial_out_pin), 9'h001);
      cyc(10);
      {idle_mode, halt_in_idle_bit} = 2'h0;
      cyc(60);
      idle_mode = 1'b1;
      peer_u.send(9'h066, 8);
      take(9'h066);
      idle_mode = 1'b0;
      $display("idle done");
      report_and_stop;
   end

   initial begin
      #40000;
      n_errors++;
      report_and_stop;
   end
endmodule

bind ubl_top ubl_checker chk_u (.*);
